/* File: regset_pkg.sv */
// shared widths, constants and encodings of the processor register set
package regset_pkg;

  // ****************************************************************
  // widths and fixed values
  // ****************************************************************
  localparam int WORD_W     = 12;
  localparam int OPC_W      = 3;
  localparam int OPC_LSB    = WORD_W - OPC_W;   // opcode sits in the top bits
  localparam int OPC_COUNT  = 8;
  localparam int MEM_WORDS  = 4096;
  localparam int SYNC_DEPTH = 3;
  localparam logic [WORD_W-1:0]    WORD_RST = 12'h000;
  localparam logic [WORD_W-1:0]    WORD_ONE = 12'h001;
  localparam logic [OPC_W-1:0]     OPC_RST  = 3'h0;
  localparam logic [OPC_COUNT-1:0] LVL_RST  = 8'h01;

  // ****************************************************************
  // gating network, arithmetic and console encodings
  // ****************************************************************
  typedef enum logic [2:0] {
    SRC_OPERAND = 3'b000,
    SRC_POINTER = 3'b001,
    SRC_ADDRESS = 3'b010,
    SRC_BUFFER  = 3'b011,
    SRC_CAPTURE = 3'b100,
    SRC_TOGGLE  = 3'b101,
    SRC_EXT     = 3'b110,
    SRC_NONE    = 3'b111
  } src_sel_t;

  typedef enum logic [1:0] {
    DST_OPERAND = 2'b00,
    DST_POINTER = 2'b01,
    DST_ADDRESS = 2'b10,
    DST_BUFFER  = 2'b11
  } dst_sel_t;

  typedef enum logic [1:0] {
    XOP_PASS = 2'b00,
    XOP_COMP = 2'b01,
    XOP_INC  = 2'b10,
    XOP_ZERO = 2'b11
  } xop_t;

  typedef enum logic [1:0] {
    AOP_ADD   = 2'b00,
    AOP_AND   = 2'b01,
    AOP_CLEAR = 2'b10,
    AOP_CLINK = 2'b11
  } aop_t;

  typedef enum logic [1:0] {
    CON_IDLE    = 2'b00,
    CON_WRITE   = 2'b01,
    CON_READ    = 2'b10,
    CON_ADVANCE = 2'b11
  } con_state_t;

endpackage : regset_pkg

/* File: opcode_if.sv */
// opcode carrier between the register set and its decoder
`timescale 1ns/1ps
`default_nettype none
interface opcode_if;
  import regset_pkg::*;
  logic [OPC_W-1:0]     opcode;
  logic [OPC_COUNT-1:0] levels;
  modport holder (output opcode, input levels);
  modport decoder (input opcode, output levels);
endinterface : opcode_if
`default_nettype wire

/* File: opcode_decoder.sv */
// one-hot decoder of the opcode into instruction levels
`timescale 1ns/1ps
`default_nettype none
module opcode_decoder (
  opcode_if.decoder opc
);
  import regset_pkg::*;

  // ****************************************************************
  // one level per basic instruction
  // ****************************************************************
  for (genvar g = 0; g < OPC_COUNT; g++) begin : g_lvl
    assign opc.levels[g] = (opc.opcode == OPC_W'(g));
  end

endmodule : opcode_decoder
`default_nettype wire

/* File: regset_core.sv */
// major register set: operand, link, pointer, address, buffer, capture, opcode
`timescale 1ns/1ps
`default_nettype none
//
// How it works
// - a 12-bit operand register passes words to memory and peripherals only through the gates and the buffer.
// - add, and and clear results are formed into the operand register.
// - a one-bit link extends the operand register and is complemented by the add carry.
// - a 12-bit pointer holds the location of the next instruction.
// - a 12-bit address register selects one of 4096 words for read or write.
// - every word bound for memory sits first in the 12-bit write buffer.
// - the buffer loads from any gate source, from a data break, or from the toggle word on a console store.
// - the buffer drives the memory write data, the peripheral interface and the gates.
// - every word read from memory is strobed into a 12-bit capture register fed only by memory.
// - the capture register feeds the opcode directly and other registers through the gates.
// - on a fetch the opcode register takes the top three bits of the captured word.
// - the opcode is decoded into eight separate instruction levels.
// - the address-set key copies the toggle word into the pointer and address registers.
// - each store, or each inspect not pressed with the address-set key, advances the address register by one.
module regset_core #(
  parameter int ADDR_SPAN = 4096
) (
  input  wire  logic                                CLK_I,
  input  wire  logic                                RESET_I,
  input  wire  logic [regset_pkg::WORD_W-1:0]       TOGGLE_WORD_I,
  input  wire  logic                                ADDR_SET_KEY_I,
  input  wire  logic                                STORE_KEY_I,
  input  wire  logic                                INSPECT_KEY_I,
  input  wire  logic                                XFER_STB_I,
  input  wire  regset_pkg::src_sel_t                XFER_SRC_I,
  input  wire  regset_pkg::dst_sel_t                XFER_DST_I,
  input  wire  regset_pkg::xop_t                    XFER_OP_I,
  input  wire  logic                                ALU_STB_I,
  input  wire  regset_pkg::aop_t                    ALU_OP_I,
  input  wire  logic [regset_pkg::WORD_W-1:0]       EXT_DATA_I,
  input  wire  logic                                BREAK_STB_I,
  input  wire  logic                                MEM_RDATA_STB_I,
  input  wire  logic [regset_pkg::WORD_W-1:0]       MEM_RDATA_I,
  input  wire  logic                                FETCH_I,
  input  wire  logic                                MEM_WRITE_REQ_I,
  input  wire  logic                                MEM_READ_REQ_I,
  output logic [regset_pkg::WORD_W-1:0]             OPERAND_O,
  output logic                                      LINK_O,
  output logic [regset_pkg::WORD_W-1:0]             POINTER_O,
  output logic [regset_pkg::WORD_W-1:0]             MEM_ADDR_O,
  output logic [regset_pkg::WORD_W-1:0]             MEM_WDATA_O,
  output logic                                      MEM_WRITE_O,
  output logic                                      MEM_READ_O,
  output logic [regset_pkg::WORD_W-1:0]             IO_DATA_O,
  output logic [regset_pkg::WORD_W-1:0]             CAPTURE_O,
  output logic [regset_pkg::OPC_W-1:0]              OPCODE_O,
  output logic [regset_pkg::OPC_COUNT-1:0]          OPCODE_LEVELS_O,
  output logic                                      CONSOLE_BUSY_O
);
  import regset_pkg::*;

  localparam int PIN_W = WORD_W + 3;

  if (ADDR_SPAN != (1 << WORD_W)) begin : g_bad_span
    $error("address span must match the address register width");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [WORD_W-1:0]    main_operand_register_q;
  logic                 link_q;
  logic [WORD_W-1:0]    next_instruction_pointer_q;
  logic [WORD_W-1:0]    memory_location_select_q;
  logic [WORD_W-1:0]    write_buffer_word_q;
  logic [WORD_W-1:0]    read_capture_q;
  logic [OPC_W-1:0]     opcode_holder_q;
  logic [OPC_COUNT-1:0] levels_q;
  logic                 mem_write_q;
  logic                 mem_read_q;
  logic                 busy_q;
  con_state_t           con_state_q;
  con_state_t           con_state_d;
  logic [PIN_W-1:0]     pin_s1_q;
  logic [PIN_W-1:0]     pin_s2_q;
  logic [PIN_W-1:0]     pin_s3_q;
  logic [PIN_W-1:0]     pin_f_q;
  logic [PIN_W-1:0]     pin_f_d;

  opcode_if opc ();

  opcode_decoder u_dec (
    .opc (opc.decoder)
  );

  // ****************************************************************
  // console pin synchronisers
  // ****************************************************************
  // three stages; a bit counts once stages two and three agree
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_f_q  <= '0;
    end else begin
      pin_s1_q <= {TOGGLE_WORD_I, ADDR_SET_KEY_I, STORE_KEY_I, INSPECT_KEY_I};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= pin_f_d;
    end
  end

  // per-bit filter keeps the old value while the stages disagree
  assign pin_f_d = (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));

  wire [WORD_W-1:0] console_toggle_word = pin_f_q[PIN_W-1:3];
  wire addr_set_key = pin_f_d[2] & ~pin_f_q[2];
  wire store_key    = pin_f_d[1] & ~pin_f_q[1];
  wire inspect_key  = pin_f_d[0] & ~pin_f_q[0];
  wire [WORD_W-1:0] toggle_next = pin_f_d[PIN_W-1:3];

  // ****************************************************************
  // console sequencer
  // ****************************************************************
  wire con_idle = (con_state_q == CON_IDLE);
  wire con_go   = con_idle & (addr_set_key | store_key | inspect_key);
  // program traffic is dropped while the console owns the registers
  wire prog_ok  = con_idle & ~con_go;

  always_comb begin
    con_state_d = con_state_q;
    case (con_state_q)
      CON_IDLE: begin
        if (store_key) begin
          con_state_d = CON_WRITE;
        end else if (inspect_key & ~addr_set_key) begin
          con_state_d = CON_READ;
        end
      end
      CON_WRITE:   con_state_d = CON_ADVANCE;
      CON_READ:    con_state_d = CON_ADVANCE;
      CON_ADVANCE: con_state_d = CON_IDLE;
      default:     con_state_d = CON_IDLE;
    endcase
  end

  // ****************************************************************
  // gating network
  // ****************************************************************
  wire [WORD_W-1:0] gate_src =
    (XFER_SRC_I == SRC_OPERAND) ? main_operand_register_q    :
    (XFER_SRC_I == SRC_POINTER) ? next_instruction_pointer_q :
    (XFER_SRC_I == SRC_ADDRESS) ? memory_location_select_q   :
    (XFER_SRC_I == SRC_BUFFER)  ? write_buffer_word_q        :
    (XFER_SRC_I == SRC_CAPTURE) ? read_capture_q             :
    (XFER_SRC_I == SRC_TOGGLE)  ? console_toggle_word        :
    (XFER_SRC_I == SRC_EXT)     ? EXT_DATA_I                 : WORD_RST;
  wire [WORD_W-1:0] gate_out =
    (XFER_OP_I == XOP_COMP) ? ~gate_src             :
    (XFER_OP_I == XOP_INC)  ? gate_src + WORD_ONE   :
    (XFER_OP_I == XOP_ZERO) ? WORD_RST              : gate_src;
  wire xfer_go = XFER_STB_I & prog_ok;
  wire to_op   = xfer_go & (XFER_DST_I == DST_OPERAND);
  wire to_ptr  = xfer_go & (XFER_DST_I == DST_POINTER);
  wire to_adr  = xfer_go & (XFER_DST_I == DST_ADDRESS);
  wire to_buf  = xfer_go & (XFER_DST_I == DST_BUFFER);
  // a data break outranks a gated load of the buffer
  wire brk_go  = BREAK_STB_I & prog_ok;
  // arithmetic yields to a transfer into the operand register
  wire alu_go  = ALU_STB_I & prog_ok & ~to_op;

  // ****************************************************************
  // arithmetic unit, operand from the capture register
  // ****************************************************************
  wire [WORD_W:0] sum = {1'b0, main_operand_register_q} + {1'b0, read_capture_q};

  // ****************************************************************
  // operand register and link
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      main_operand_register_q <= WORD_RST;
      link_q                  <= 1'b0;
    end else if (to_op) begin
      main_operand_register_q <= gate_out;
    end else if (alu_go) begin
      case (ALU_OP_I)
        AOP_ADD: begin
          main_operand_register_q <= sum[WORD_W-1:0];
          link_q                  <= link_q ^ sum[WORD_W];
        end
        AOP_AND:   main_operand_register_q <= main_operand_register_q & read_capture_q;
        AOP_CLEAR: main_operand_register_q <= WORD_RST;
        AOP_CLINK: link_q <= 1'b0;
        default:   link_q <= link_q;
      endcase
    end
  end

  // ****************************************************************
  // pointer and address registers
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      next_instruction_pointer_q <= WORD_RST;
      memory_location_select_q   <= WORD_RST;
    end else begin
      if (con_idle & addr_set_key) begin
        next_instruction_pointer_q <= toggle_next;
        memory_location_select_q   <= toggle_next;
      end else if (con_state_q == CON_ADVANCE) begin
        memory_location_select_q   <= memory_location_select_q + WORD_ONE;
      end else begin
        if (to_ptr) begin
          next_instruction_pointer_q <= gate_out;
        end
        if (to_adr) begin
          memory_location_select_q <= gate_out;
        end
      end
    end
  end

  // ****************************************************************
  // write buffer and capture register
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      write_buffer_word_q <= WORD_RST;
    end else if (con_idle & store_key) begin
      write_buffer_word_q <= toggle_next;
    end else if (brk_go) begin
      write_buffer_word_q <= EXT_DATA_I;
    end else if (to_buf) begin
      write_buffer_word_q <= gate_out;
    end
  end

  // memory is the only source of the capture register
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      read_capture_q <= WORD_RST;
    end else if (MEM_RDATA_STB_I) begin
      read_capture_q <= MEM_RDATA_I;
    end
  end

  // ****************************************************************
  // opcode register and decoded levels
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      opcode_holder_q <= OPC_RST;
      levels_q        <= LVL_RST;
    end else begin
      if (FETCH_I) begin
        opcode_holder_q <= read_capture_q[WORD_W-1:OPC_LSB];
      end
      levels_q <= opc.levels;
    end
  end

  assign opc.opcode = opcode_holder_q;

  // ****************************************************************
  // memory strobes and sequencer state
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mem_write_q <= 1'b0;
      mem_read_q  <= 1'b0;
      busy_q      <= 1'b0;
      con_state_q <= CON_IDLE;
    end else begin
      // busy flag registered from the next state so the pin comes from a flip-flop
      busy_q      <= (con_state_d != CON_IDLE);
      mem_write_q <= (con_state_q == CON_WRITE) | (prog_ok & MEM_WRITE_REQ_I);
      mem_read_q  <= (con_state_q == CON_READ) | (prog_ok & MEM_READ_REQ_I);
      con_state_q <= con_state_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign OPERAND_O       = main_operand_register_q;
  assign LINK_O          = link_q;
  assign POINTER_O       = next_instruction_pointer_q;
  assign MEM_ADDR_O      = memory_location_select_q;
  assign MEM_WDATA_O     = write_buffer_word_q;
  assign IO_DATA_O       = write_buffer_word_q;
  assign MEM_WRITE_O     = mem_write_q;
  assign MEM_READ_O      = mem_read_q;
  assign CAPTURE_O       = read_capture_q;
  assign OPCODE_O        = opcode_holder_q;
  assign OPCODE_LEVELS_O = levels_q;
  assign CONSOLE_BUSY_O  = busy_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_store;
    con_idle && store_key;
  endsequence
  sequence s_write_then_step;
    ##2 MEM_WRITE_O ##1 1'b1;
  endsequence

  property p_addr_set;
    con_idle && addr_set_key |=> (POINTER_O == $past(toggle_next)) && (MEM_ADDR_O == POINTER_O);
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("address set not copied");

  property p_store_step;
    s_store |-> s_write_then_step ##0 (MEM_ADDR_O == $past(MEM_ADDR_O, 2) + WORD_ONE);
  endproperty
  a_store_step: assert property (p_store_step) else $error("store did not advance");

  property p_inspect_step;
    con_idle && inspect_key && !store_key && !addr_set_key
      |=> ##1 MEM_READ_O ##1 (MEM_ADDR_O == $past(MEM_ADDR_O, 2) + WORD_ONE);
  endproperty
  a_inspect_step: assert property (p_inspect_step) else $error("inspect did not advance");

  property p_store_data;
    s_store |=> (MEM_WDATA_O == $past(toggle_next)) ##1 MEM_WRITE_O;
  endproperty
  a_store_data: assert property (p_store_data) else $error("store word not buffered");

  property p_fetch;
    FETCH_I |=> OPCODE_O == $past(read_capture_q[WORD_W-1:OPC_LSB]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("opcode not fetched");

  property p_levels;
    $onehot(OPCODE_LEVELS_O) && OPCODE_LEVELS_O[$past(OPCODE_O)];
  endproperty
  a_levels: assert property (p_levels) else $error("bad instruction level");

  property p_capture_src;
    !MEM_RDATA_STB_I |=> $stable(CAPTURE_O);
  endproperty
  a_capture_src: assert property (p_capture_src) else $error("capture changed w/o read");

  property p_add_carry;
    alu_go && ALU_OP_I == AOP_ADD
      |=> {LINK_O ^ $past(LINK_O), OPERAND_O} == $past(sum);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add or carry wrong");

  property p_io_path;
    IO_DATA_O == MEM_WDATA_O;
  endproperty
  a_io_path: assert property (p_io_path) else $error("buffer paths differ");

  property p_break;
    brk_go |=> MEM_WDATA_O == $past(EXT_DATA_I);
  endproperty
  a_break: assert property (p_break) else $error("data break not loaded");

  property p_xfer_op;
    to_op |=> OPERAND_O == $past(gate_out);
  endproperty
  a_xfer_op: assert property (p_xfer_op) else $error("operand transfer lost");

endmodule : regset_core
`default_nettype wire

/* File: core_mem_model.sv */
// behavioural core memory answering the register set's read and write pulses
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [11:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        slow_i,
  output logic             stb_o,
  output logic [11:0]      data_o
);
  logic [11:0] mem_q [0:4095];
  logic [11:0] a_q;
  // preload: every word holds the inverse of its own address
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem_q[i] = ~i[11:0];
    end
  end
  // write lands with the address held while the pulse stands
  always @(posedge clk_i) begin
    #2;
    if (wr_i === 1'b1 && !rst_i) mem_q[addr_i] = wdata_i;
  end
  // answer a read promptly or three cycles late; the data line never keeps a stale word
  initial begin
    stb_o = 1'b0;
    data_o = 12'hFFF;
    forever begin
      @(posedge clk_i);
      #2;
      if (rd_i === 1'b1 && !rst_i) begin
        a_q = addr_i;
        if (slow_i) begin
          repeat (3) @(posedge clk_i);
          #2;
        end
        stb_o = 1'b1;
        data_o = mem_q[a_q];
        @(posedge clk_i);
        #2;
        stb_o = 1'b0;
        data_o = ~mem_q[a_q];
      end
    end
  end
endmodule : core_mem_model
`default_nettype wire

/* File: processor_major_register_set_bench.sv */
// self-checking bench of the register set against a behavioural core memory
`timescale 1ns/1ps
`default_nettype none
module processor_major_register_set_bench import regset_pkg::*;;
  logic CLK_I, RESET_I, ADDR_SET_KEY_I, STORE_KEY_I, INSPECT_KEY_I, XFER_STB_I, ALU_STB_I;
  logic BREAK_STB_I, MEM_RDATA_STB_I, FETCH_I, MEM_WRITE_REQ_I, MEM_READ_REQ_I, slow;
  logic LINK_O, MEM_WRITE_O, MEM_READ_O, CONSOLE_BUSY_O;
  logic [11:0] TOGGLE_WORD_I, EXT_DATA_I, MEM_RDATA_I, OPERAND_O, POINTER_O, MEM_ADDR_O;
  logic [11:0] MEM_WDATA_O, IO_DATA_O, CAPTURE_O, w, a, v;
  logic [2:0]  OPCODE_O;
  logic [7:0]  OPCODE_LEVELS_O;
  logic [31:0] rnd = 32'h00010F0F;
  src_sel_t    XFER_SRC_I;
  dst_sel_t    XFER_DST_I;
  xop_t        XFER_OP_I;
  aop_t        ALU_OP_I;
  int          fails = 0, comparisons = 0, cyc = 0;
  typedef struct { string name; logic [11:0] val; int cyc; } note_t;
  note_t notes[$];

  regset_core #(.ADDR_SPAN(4096)) dut_u (.CLK_I, .RESET_I, .TOGGLE_WORD_I, .ADDR_SET_KEY_I,
    .STORE_KEY_I, .INSPECT_KEY_I, .XFER_STB_I, .XFER_SRC_I, .XFER_DST_I, .XFER_OP_I, .ALU_STB_I,
    .ALU_OP_I, .EXT_DATA_I, .BREAK_STB_I, .MEM_RDATA_STB_I, .MEM_RDATA_I, .FETCH_I,
    .MEM_WRITE_REQ_I, .MEM_READ_REQ_I, .OPERAND_O, .LINK_O, .POINTER_O, .MEM_ADDR_O,
    .MEM_WDATA_O, .MEM_WRITE_O, .MEM_READ_O, .IO_DATA_O, .CAPTURE_O, .OPCODE_O,
    .OPCODE_LEVELS_O, .CONSOLE_BUSY_O);
  core_mem_model mem_u (.clk_i(CLK_I), .rst_i(RESET_I), .addr_i(MEM_ADDR_O),
    .wdata_i(MEM_WDATA_O), .wr_i(MEM_WRITE_O), .rd_i(MEM_READ_O), .slow_i(slow),
    .stb_o(MEM_RDATA_STB_I), .data_o(MEM_RDATA_I));

  // ****************************************************************
  // clock, cycle count, helpers
  // ****************************************************************
  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) cyc <= cyc + 1;
  function automatic logic [11:0] rand12();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[11:0];
  endfunction : rand12
  function automatic logic [11:0] seen(input string n);
    case (n)
      "operand": return OPERAND_O;
      "link":    return {11'h000, LINK_O};
      "pointer": return POINTER_O;
      "addr":    return MEM_ADDR_O;
      "wdata":   return MEM_WDATA_O;
      "io":      return IO_DATA_O;
      "capture": return CAPTURE_O;
      "opcode":  return {9'h000, OPCODE_O};
      "levels":  return {4'h0, OPCODE_LEVELS_O};
      "wr":      return {11'h000, MEM_WRITE_O};
      "rd":      return {11'h000, MEM_READ_O};
      "busy":    return {11'h000, CONSOLE_BUSY_O};
      default:   return {11'h000, MEM_RDATA_STB_I};
    endcase
  endfunction : seen
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge CLK_I);
      #1;
    end
  endtask : tick
  task automatic note(input string n, input logic [11:0] e);
    notes.push_back('{n, e, cyc});
  endtask : note
  task automatic check_word(input string n, input logic [11:0] e, input logic [11:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check_word
  task automatic check_flag(input string n, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask : check_flag
  // watcher: every note due by this cycle is compared, oldest first, against the settled outputs
  always @(negedge CLK_I) begin
    while (notes.size() > 0 && notes[0].cyc <= cyc) begin
      v = seen(notes[0].name);
      if (notes[0].name inside {"link", "wr", "rd", "busy"}) check_flag(notes[0].name, notes[0].val[0], v[0]);
      else check_word(notes[0].name, notes[0].val, v);
      void'(notes.pop_front());
    end
  end
  // bounded wait on a pulse; a lost answer counts as a mismatch
  task automatic wait_for(input string n);
    logic [11:0] s;
    s = seen(n);
    for (int k = 0; k < 20 && s[0] !== 1'b1; k++) begin
      tick(1);
      s = seen(n);
    end
    check_flag(n, 1'b1, s[0]);
  endtask : wait_for
  task automatic xfer(input src_sel_t s, input dst_sel_t d, input xop_t o, input logic [11:0] x);
    {XFER_SRC_I, XFER_DST_I, XFER_OP_I, EXT_DATA_I, XFER_STB_I} = {s, d, o, x, 1'b1};
    tick(1);
    XFER_STB_I = 1'b0;
    tick(1);
  endtask : xfer
  task automatic alu(input aop_t o);
    {ALU_OP_I, ALU_STB_I} = {o, 1'b1};
    tick(1);
    ALU_STB_I = 1'b0;
    tick(1);
  endtask : alu
  task automatic mem_read(input logic [11:0] x);
    xfer(SRC_EXT, DST_ADDRESS, XOP_PASS, x);
    slow = rnd[3];
    MEM_READ_REQ_I = 1'b1;
    tick(1);
    MEM_READ_REQ_I = 1'b0;
    note("rd", 12'h001);
    wait_for("stb");
  endtask : mem_read
  // keys in order addr-set, store, inspect; toggle word settles through its filter first
  task automatic keys(input logic [2:0] m, input logic [11:0] t);
    TOGGLE_WORD_I = t;
    tick(6);
    {ADDR_SET_KEY_I, STORE_KEY_I, INSPECT_KEY_I} = m;
  endtask : keys
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    fails++;
    stop_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {ADDR_SET_KEY_I, STORE_KEY_I, INSPECT_KEY_I, XFER_STB_I, ALU_STB_I, BREAK_STB_I} = '0;
    {FETCH_I, MEM_WRITE_REQ_I, MEM_READ_REQ_I, slow, TOGGLE_WORD_I, EXT_DATA_I} = '0;
    {XFER_SRC_I, XFER_DST_I, XFER_OP_I, ALU_OP_I} = {SRC_NONE, DST_OPERAND, XOP_PASS, AOP_ADD};
    RESET_I = 1'b1;
    tick(12);
    RESET_I = 1'b0;
    note("operand", 12'h000);
    note("levels", 12'h001);
    $display("test reset done");
    // gated transfers and in-place operations, incl. increment wrap
    w = rand12();
    xfer(SRC_EXT, DST_OPERAND, XOP_PASS, w);
    note("operand", w);
    xfer(SRC_OPERAND, DST_OPERAND, XOP_COMP, 12'h000);
    note("operand", ~w);
    xfer(SRC_OPERAND, DST_POINTER, XOP_INC, 12'h000);
    note("pointer", ~w + 12'h001);
    xfer(SRC_EXT, DST_OPERAND, XOP_PASS, 12'hFFF);
    xfer(SRC_OPERAND, DST_OPERAND, XOP_INC, 12'h000);
    note("operand", 12'h000);
    $display("test transfer done");
    // program write through the buffer, read back, then a data break
    a = rand12();
    w = rand12();
    xfer(SRC_EXT, DST_ADDRESS, XOP_PASS, a);
    xfer(SRC_EXT, DST_BUFFER, XOP_PASS, w);
    note("wdata", w);
    note("io", w);
    MEM_WRITE_REQ_I = 1'b1;
    tick(1);
    MEM_WRITE_REQ_I = 1'b0;
    note("wr", 12'h001);
    mem_read(a);
    note("capture", w);
    {EXT_DATA_I, BREAK_STB_I} = {~w, 1'b1};
    tick(1);
    BREAK_STB_I = 1'b0;
    note("wdata", ~w);
    $display("test memory done");
    // every opcode: word at k<<9 holds ~(k<<9), so its top bits are 7-k
    for (int k = 0; k < 8; k++) begin
      mem_read({k[2:0], 9'h000});
      note("capture", ~{k[2:0], 9'h000});
      FETCH_I = 1'b1;
      tick(1);
      FETCH_I = 1'b0;
      note("opcode", 12'h007 - k[11:0]);
      tick(1);
      note("levels", 12'h001 << (7 - k));
    end
    $display("test fetch done");
    // arithmetic against the captured word 001
    xfer(SRC_EXT, DST_OPERAND, XOP_PASS, 12'hFFF);
    mem_read(12'hFFE);
    alu(AOP_ADD);
    note("operand", 12'h000);
    note("link", 12'h001);
    alu(AOP_CLINK);
    note("link", 12'h000);
    xfer(SRC_EXT, DST_OPERAND, XOP_PASS, 12'hFFF);
    alu(AOP_AND);
    note("operand", 12'h001);
    alu(AOP_CLEAR);
    note("operand", 12'h000);
    $display("test arith done");
    // console: address set, store with a refused transfer, inspect back
    a = rand12();
    w = rand12();
    keys(3'b100, a);
    tick(8);
    note("pointer", a);
    note("addr", a);
    keys(3'b000, w);
    keys(3'b010, w);
    wait_for("wr");
    note("wdata", w);
    note("busy", 12'h001);
    xfer(SRC_EXT, DST_OPERAND, XOP_PASS, 12'h5A5);
    note("addr", a + 12'h001);
    note("operand", 12'h000);
    keys(3'b000, a);
    keys(3'b100, a);
    tick(8);
    keys(3'b000, a);
    keys(3'b001, a);
    wait_for("rd");
    tick(1);
    note("addr", a + 12'h001);
    wait_for("stb");
    note("capture", w);
    keys(3'b000, a);
    tick(4);
    note("busy", 12'h000);
    tick(1);
    $display("test console done");
    stop_test();
  end
endmodule : processor_major_register_set_bench
`default_nettype wire
